// ===== rtl/multi_queue_port.sv
// Four-queue word buffer with a shared write port and a shared read port.
// Assumes all pins are asynchronous to MCLK; both ports run on MCLK.
`timescale 1ns/1ps

module multi_queue_port #(
  parameter int DEPTH = mq_pkg::QUEUE_DEPTH,
  parameter int AF_GAP = mq_pkg::ALMOST_FULL_GAP,
  parameter int AE_LEVEL = mq_pkg::ALMOST_EMPTY_LEVEL
) (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Configuration pins
  input wire logic PACKET_MODE_SELECT,
  input wire logic [mq_pkg::CHIP_POS_W-1:0] CHIP_POSITION_PINS,
  // Write port
  input wire logic [mq_pkg::DATA_W-1:0] DIN,
  input wire logic WRITE_ENABLE_N,
  input wire logic WRITE_ADDRESS_ENABLE,
  input wire logic FULL_FLAG_STROBE,
  input wire logic [mq_pkg::WADDR_W-1:0] WRITE_QUEUE_ADDR_BUS,
  output logic FULL_FLAG_N,
  output logic [mq_pkg::NUM_QUEUES-1:0] ALMOST_FULL_FLAG_N,
  // Read port
  input wire logic READ_ENABLE_N,
  input wire logic READ_ADDRESS_ENABLE,
  input wire logic EMPTY_FLAG_STROBE,
  input wire logic [mq_pkg::RADDR_W-1:0] READ_QUEUE_ADDR_BUS,
  input wire logic OUTPUT_ENABLE_N,
  output logic [mq_pkg::DATA_W-1:0] QOUT,
  output logic QOUT_OE,
  output logic OUTPUT_VALID_FLAG_N,
  output logic EMPTY_FLAG_N,
  output logic PACKET_READY_FLAG_N,
  output logic [mq_pkg::NUM_QUEUES-1:0] ALMOST_EMPTY_FLAG_N
);

  localparam int NQ = mq_pkg::NUM_QUEUES;
  localparam int QW = mq_pkg::QSEL_W;
  localparam int DW = mq_pkg::DATA_W;
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;
  localparam int PIN_W = 3 + DW + mq_pkg::WADDR_W + 4
                       + mq_pkg::RADDR_W + 1 + mq_pkg::CHIP_POS_W;
  localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
  localparam logic [CW-1:0] AF_CNT = CW'(DEPTH - AF_GAP);
  localparam logic [CW-1:0] AE_CNT = CW'(AE_LEVEL);
  localparam logic [1:0] FLUSH_CNT = 2'(mq_pkg::QCHANGE_FLUSH);
  localparam logic [1:0] CAP_EDGE = 2'(mq_pkg::MODE_CAPTURE_EDGE);

  // ==========================================================
  // Pin synchronisers
  logic [PIN_W-1:0] pin_raw;
  logic [PIN_W-1:0] sync1;
  logic [PIN_W-1:0] sync2;

  assign pin_raw = {PACKET_MODE_SELECT, CHIP_POSITION_PINS, DIN,
                    WRITE_ENABLE_N, WRITE_ADDRESS_ENABLE,
                    FULL_FLAG_STROBE, WRITE_QUEUE_ADDR_BUS,
                    READ_ENABLE_N, READ_ADDRESS_ENABLE,
                    EMPTY_FLAG_STROBE, READ_QUEUE_ADDR_BUS,
                    OUTPUT_ENABLE_N};

  // Two flip-flops on every pin except MCLK and SYS_RST before any logic looks at it
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      sync1 <= '0;
      sync2 <= '0;
    end else begin
      sync1 <= pin_raw;
      sync2 <= sync1;
    end
  end

  logic s_pkt;
  logic [mq_pkg::CHIP_POS_W-1:0] s_pos;
  logic [DW-1:0] s_din;
  logic s_wen_n;
  logic s_write_address_enable;
  logic s_full_flag_strobe;
  logic [mq_pkg::WADDR_W-1:0] s_waddr;
  logic s_ren_n;
  logic s_read_address_enable;
  logic s_empty_flag_strobe;
  logic [mq_pkg::RADDR_W-1:0] s_raddr;
  logic s_oe_n;

  assign {s_pkt, s_pos, s_din, s_wen_n, s_write_address_enable, s_full_flag_strobe, s_waddr,
          s_ren_n, s_read_address_enable, s_empty_flag_strobe, s_raddr, s_oe_n} = sync2;

  // ==========================================================
  // Mode capture after reset release
  logic pkt_mode;
  logic [1:0] cap_cnt;

  // The mode pin is caught once its synchroniser has settled
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      cap_cnt <= 2'h0;
      pkt_mode <= 1'b0;
    end else if (cap_cnt != CAP_EDGE + 2'h1) begin
      // Pin value reaches the second sync flop one edge before the capture edge
      cap_cnt <= cap_cnt + 2'h1;
      if (cap_cnt == CAP_EDGE) begin
        pkt_mode <= s_pkt;
      end
    end
  end

  // ==========================================================
  // Address decode
  logic w_match;
  logic r_match;
  logic w_qsel;
  logic w_fsel;
  logic r_qsel;
  logic r_fsel;

  // Device select bits compared with the chip position
  assign w_match = s_waddr[mq_pkg::WADDR_W-1:mq_pkg::WDEV_LSB] == s_pos;
  assign r_match = s_raddr[mq_pkg::RADDR_W-1:mq_pkg::RDEV_LSB] == s_pos;
  assign w_qsel = s_write_address_enable && !s_full_flag_strobe;
  assign w_fsel = !s_write_address_enable && s_full_flag_strobe;
  assign r_qsel = s_read_address_enable && !s_empty_flag_strobe;
  assign r_fsel = !s_read_address_enable && s_empty_flag_strobe;

  // ==========================================================
  // Queue storage and occupancy
  logic [DW-1:0] mem [NQ*DEPTH];
  logic [PW-1:0] wptr [NQ];
  logic [PW-1:0] rptr [NQ];
  logic [CW-1:0] cnt [NQ];
  logic [CW-1:0] pkts [NQ];

  // ==========================================================
  // Write queue selection
  logic [QW-1:0] wq;
  logic [QW-1:0] wq_next;
  logic w_on;
  logic w_on_next;
  logic wchg;
  logic wr_go;

  // Selection is taken on the first edge, applied on the second
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wq <= mq_pkg::RESET_QUEUE;
      wq_next <= mq_pkg::RESET_QUEUE;
      w_on <= 1'b0;
      w_on_next <= 1'b0;
      wchg <= 1'b0;
    end else begin
      wchg <= w_qsel;
      if (w_qsel) begin
        wq_next <= s_waddr[QW-1:mq_pkg::QADDR_LSB];
        w_on_next <= w_match;
      end
      if (wchg) begin
        wq <= wq_next;
        w_on <= w_on_next;
      end
    end
  end

  // Old queue keeps taking words until the switch edge
  assign wr_go = !s_wen_n && w_on && (cnt[wq] != FULL_CNT);

  // ==========================================================
  // Read queue selection
  logic [QW-1:0] rq;
  logic [QW-1:0] rq_next;
  logic r_on;
  logic r_on_next;
  logic rchg;

  // Same two-cycle switch on the read side
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      rq <= mq_pkg::RESET_QUEUE;
      rq_next <= mq_pkg::RESET_QUEUE;
      r_on <= 1'b0;
      r_on_next <= 1'b0;
      rchg <= 1'b0;
    end else begin
      rchg <= r_qsel;
      if (r_qsel) begin
        rq_next <= s_raddr[QW-1:mq_pkg::QADDR_LSB];
        r_on_next <= r_match;
      end
      if (rchg) begin
        rq <= rq_next;
        r_on <= r_on_next;
      end
    end
  end

  // ==========================================================
  // Two-entry buffer between queue and output register
  logic [DW-1:0] buf_word [2];
  logic buf_wp;
  logic buf_rp;
  logic [1:0] buf_cnt;
  logic buf_in_ready;
  logic buf_out_valid;
  logic fetch;
  logic pop;
  logic out_valid;
  logic [1:0] flush;
  logic [DW-1:0] fetch_word;

  assign buf_in_ready = buf_cnt != 2'h2;
  assign buf_out_valid = buf_cnt != 2'h0;
  assign fetch_word = mem[{rq, rptr[rq]}];

  // In packet mode a queue feeds the buffer only when it holds a whole packet
  assign fetch = buf_in_ready && r_on && (cnt[rq] != '0)
               && (!pkt_mode || pkts[rq] != '0);

  // The output register drains the buffer; a queue change forces it
  assign pop = buf_out_valid
             && (!out_valid || !s_ren_n || flush != 2'h0);

  // Buffer pointers and storage
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      buf_wp <= 1'b0;
      buf_rp <= 1'b0;
      buf_cnt <= 2'h0;
    end else begin
      if (fetch) begin
        buf_word[buf_wp] <= fetch_word;
        buf_wp <= !buf_wp;
      end
      if (pop) begin
        buf_rp <= !buf_rp;
      end
      buf_cnt <= buf_cnt + {1'b0, fetch} - {1'b0, pop};
    end
  end

  // Forced hand-over of the old and new words after a switch
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      flush <= 2'h0;
    end else if (r_qsel) begin
      flush <= FLUSH_CNT;
    end else if (flush != 2'h0) begin
      // Window lasts two cycles even when the new queue is empty
      flush <= flush - 2'h1;
    end
  end

  // ==========================================================
  // Queue pointers, counts and complete-packet counts
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      for (int q = 0; q < NQ; q++) begin
        wptr[q] <= '0;
        rptr[q] <= '0;
        cnt[q] <= '0;
        pkts[q] <= '0;
      end
    end else begin
      for (int q = 0; q < NQ; q++) begin
        if (wr_go && wq == QW'(q)) begin
          wptr[q] <= wptr[q] + PW'(1);
        end
        if (fetch && rq == QW'(q)) begin
          rptr[q] <= rptr[q] + PW'(1);
        end
        cnt[q] <= cnt[q] + CW'(wr_go && wq == QW'(q))
                - CW'(fetch && rq == QW'(q));
        pkts[q] <= pkts[q]
          + CW'(pkt_mode && wr_go && wq == QW'(q)
                && s_din[mq_pkg::EOP_BIT])
          - CW'(pkt_mode && fetch && rq == QW'(q)
                && fetch_word[mq_pkg::EOP_BIT]);
      end
    end
  end

  // Word and its markers stored together
  always_ff @(posedge MCLK) begin
    if (wr_go) begin
      mem[{wq, wptr[wq]}] <= s_din;
    end
  end

  // ==========================================================
  // Output register and valid flag
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      QOUT <= '0;
      out_valid <= 1'b0;
      OUTPUT_VALID_FLAG_N <= 1'b1;
    end else begin
      if (pop) begin
        QOUT <= buf_word[buf_rp];
        out_valid <= 1'b1;
        OUTPUT_VALID_FLAG_N <= 1'b0;
      end else if ((!s_ren_n || flush != 2'h0) && out_valid) begin
        out_valid <= 1'b0;
        OUTPUT_VALID_FLAG_N <= 1'b1;
      end
    end
  end

  // Output enable only gates the drive of the word bus
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      QOUT_OE <= 1'b0;
    end else begin
      QOUT_OE <= !s_oe_n;
    end
  end

  // ==========================================================
  // Discrete flags of the active queues
  logic [QW-1:0] wq_flag;
  logic [QW-1:0] rq_flag;

  // On the switch edge the flags follow the newly chosen queue
  assign wq_flag = wchg ? wq_next : wq;
  assign rq_flag = rchg ? rq_next : rq;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      FULL_FLAG_N <= 1'b1;
      EMPTY_FLAG_N <= 1'b0;
      PACKET_READY_FLAG_N <= 1'b1;
    end else begin
      FULL_FLAG_N <= cnt[wq_flag] != FULL_CNT;
      EMPTY_FLAG_N <= cnt[rq_flag] != '0;
      PACKET_READY_FLAG_N <= !(pkt_mode && pkts[rq_flag] != '0);
    end
  end

  // ==========================================================
  // Flag buses, shown only while this device is picked
  logic paf_on;
  logic pae_on;

  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      paf_on <= 1'b0;
      pae_on <= 1'b0;
    end else begin
      if (w_fsel) begin
        paf_on <= w_match;
      end
      if (r_fsel) begin
        pae_on <= r_match;
      end
    end
  end

  // Almost-empty bus turns into the packet ready bus in packet mode
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      ALMOST_FULL_FLAG_N <= mq_pkg::FLAG_BUS_IDLE;
      ALMOST_EMPTY_FLAG_N <= mq_pkg::FLAG_BUS_IDLE;
    end else begin
      for (int q = 0; q < NQ; q++) begin
        ALMOST_FULL_FLAG_N[q] <= !(paf_on && cnt[q] >= AF_CNT);
        if (pkt_mode) begin
          ALMOST_EMPTY_FLAG_N[q] <= !(pae_on && pkts[q] != '0);
        end else begin
          ALMOST_EMPTY_FLAG_N[q] <= !(pae_on && cnt[q] <= AE_CNT);
        end
      end
    end
  end

endmodule

// ===== include/mq_pkg.sv
// Shared constants for the four-queue word buffer port logic.
// Assumes a single 50 MHz clock and pins synchronised inside the block.
package mq_pkg;

  // ==========================================================
  // Queue organisation
  localparam int NUM_QUEUES = 4;
  localparam int QSEL_W = 2;
  localparam int QUEUE_DEPTH = 16;
  localparam int DATA_W = 36;

  // ==========================================================
  // Packet marker positions in the data word
  localparam int SOP_BIT = 34;
  localparam int EOP_BIT = 35;

  // ==========================================================
  // Address bus layouts
  localparam int WADDR_W = 5;
  localparam int RADDR_W = 6;
  localparam int CHIP_POS_W = 3;
  localparam int WDEV_LSB = 2;
  localparam int RDEV_LSB = 3;
  localparam int QADDR_LSB = 0;

  // ==========================================================
  // Flag thresholds and timing
  localparam int ALMOST_FULL_GAP = 2;
  localparam int ALMOST_EMPTY_LEVEL = 2;
  localparam int SYNC_STAGES = 2;
  localparam int MODE_CAPTURE_EDGE = 2;
  localparam int QCHANGE_FLUSH = 2;

  // ==========================================================
  // Reset values of the port state
  localparam logic [QSEL_W-1:0] RESET_QUEUE = 2'h0;
  localparam logic [NUM_QUEUES-1:0] FLAG_BUS_IDLE = 4'hF;

endpackage

// ===== tb/mq_port_assertions.sv
// Port-level checker for multi_queue_port.
// Assumes one clock MCLK and an async active-high SYS_RST.
`timescale 1ns/1ps
module mq_port_assertions (
  // Clock and reset
  input wire logic MCLK,
  input wire logic SYS_RST,
  // Watched inputs
  input wire logic PACKET_MODE_SELECT,
  input wire logic WRITE_ENABLE_N,
  input wire logic WRITE_ADDRESS_ENABLE,
  input wire logic READ_ENABLE_N,
  input wire logic READ_ADDRESS_ENABLE,
  input wire logic OUTPUT_ENABLE_N,
  // Watched outputs
  input wire logic [mq_pkg::DATA_W-1:0] QOUT,
  input wire logic QOUT_OE,
  input wire logic FULL_FLAG_N,
  input wire logic EMPTY_FLAG_N,
  input wire logic OUTPUT_VALID_FLAG_N,
  input wire logic PACKET_READY_FLAG_N
);
  // ====================
  // Helper ages, saturating so long idle spells stay bounded
  logic [3:0] since_rst;
  logic [3:0] wr_age;
  logic [3:0] rd_age;

  function automatic logic [3:0] sat(input logic [3:0] a);
    sat = (a == 4'hF) ? a : a + 4'h1;
  endfunction

  // Cycles since reset release
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      since_rst <= 4'h0;
    end else begin
      since_rst <= sat(since_rst);
    end
  end

  // Cycles since the last write or read port activity
  always_ff @(posedge MCLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      wr_age <= 4'hF;
      rd_age <= 4'hF;
    end else begin
      wr_age <= (!WRITE_ENABLE_N || WRITE_ADDRESS_ENABLE) ? 4'h0 : sat(wr_age);
      rd_age <= (!READ_ENABLE_N || READ_ADDRESS_ENABLE) ? 4'h0 : sat(rd_age);
    end
  end

  // ====================
  // Properties
  default clocking @(posedge MCLK); endclocking
  default disable iff (SYS_RST);

  a_reset_flags: assert property (
    $fell(SYS_RST) |-> FULL_FLAG_N && !EMPTY_FLAG_N && OUTPUT_VALID_FLAG_N)
    else $error("port flags wrong after reset");
  a_oe_drive_only: assert property (
    (since_rst == 4'hF && $stable(OUTPUT_ENABLE_N))[*4]
    |-> QOUT_OE == !OUTPUT_ENABLE_N)
    else $error("output drive does not follow enable");
  a_invalid_word_held: assert property (
    $past(OUTPUT_VALID_FLAG_N) && OUTPUT_VALID_FLAG_N |-> $stable(QOUT))
    else $error("output word moved while invalid");
  a_standard_no_ready: assert property (
    since_rst == 4'hF && !PACKET_MODE_SELECT |-> PACKET_READY_FLAG_N)
    else $error("packet ready shown in standard mode");
  a_full_needs_write: assert property (
    $fell(FULL_FLAG_N) |-> wr_age < 4'h8)
    else $error("full flag set without write activity");
  a_full_clear_cause: assert property (
    $rose(FULL_FLAG_N) |-> wr_age < 4'h8 || rd_age < 4'hA)
    else $error("full flag cleared without cause");
  a_empty_clear_cause: assert property (
    $rose(EMPTY_FLAG_N) |-> wr_age < 4'h8 || rd_age < 4'h8)
    else $error("empty flag cleared without cause");
  a_valid_drop_cause: assert property (
    $rose(OUTPUT_VALID_FLAG_N) |-> rd_age < 4'h8)
    else $error("valid flag dropped without a read");
endmodule

bind multi_queue_port mq_port_assertions u_chk (
  .MCLK(MCLK), .SYS_RST(SYS_RST), .PACKET_MODE_SELECT(PACKET_MODE_SELECT),
  .WRITE_ENABLE_N(WRITE_ENABLE_N), .READ_ENABLE_N(READ_ENABLE_N),
  .WRITE_ADDRESS_ENABLE(WRITE_ADDRESS_ENABLE), .QOUT(QOUT),
  .READ_ADDRESS_ENABLE(READ_ADDRESS_ENABLE), .QOUT_OE(QOUT_OE),
  .OUTPUT_ENABLE_N(OUTPUT_ENABLE_N), .FULL_FLAG_N(FULL_FLAG_N),
  .EMPTY_FLAG_N(EMPTY_FLAG_N), .OUTPUT_VALID_FLAG_N(OUTPUT_VALID_FLAG_N),
  .PACKET_READY_FLAG_N(PACKET_READY_FLAG_N));

// ===== tb/read_host.sv
// Reader host on the read port: pulls words and logs each new one.
// Assumes distinct nonzero words; the bench reads the log directly.
`timescale 1ns/1ps
module read_host (
  // Clock
  input wire logic MCLK,
  // Bench control
  input wire logic host_on,
  input wire logic host_slow,
  // Read port of the block
  input wire logic [mq_pkg::DATA_W-1:0] QOUT,
  input wire logic OUTPUT_VALID_FLAG_N,
  output logic READ_ENABLE_N
);
  logic [mq_pkg::DATA_W-1:0] got [$];
  logic [mq_pkg::DATA_W-1:0] last = '0;
  logic beat = 1'b0;

  // Log each valid word once, sampled where it has settled
  always @(negedge MCLK) begin
    if (OUTPUT_VALID_FLAG_N === 1'b0 && QOUT !== last) begin
      got.push_back(QOUT);
      last = QOUT;
    end
  end

  // Read every cycle, or every other cycle when slow
  always @(posedge MCLK) begin
    beat = !beat;
    #1;
    READ_ENABLE_N = !(host_on && (!host_slow || beat));
  end
endmodule

// ===== tb/testbench.sv
// Self-checking bench for multi_queue_port with a reader host.
// Assumes the checker is bound in and queues are 4 words deep here.
`timescale 1ns/1ps
module testbench;
  localparam logic [2:0] CHIP = 3'h5;
  logic MCLK, SYS_RST, PACKET_MODE_SELECT, WRITE_ENABLE_N;
  logic WRITE_ADDRESS_ENABLE, READ_ENABLE_N, READ_ADDRESS_ENABLE;
  logic EMPTY_FLAG_STROBE, OUTPUT_ENABLE_N, QOUT_OE, FULL_FLAG_N;
  logic OUTPUT_VALID_FLAG_N, EMPTY_FLAG_N, PACKET_READY_FLAG_N;
  logic host_on, host_slow;
  logic [35:0] DIN, QOUT;
  logic [4:0] WRITE_QUEUE_ADDR_BUS;
  logic [5:0] READ_QUEUE_ADDR_BUS;
  logic [3:0] ALMOST_EMPTY_FLAG_N;
  int n_errors = 0;
  int n_checks = 0;

  // ====================
  // Block and reader host
  multi_queue_port #(.DEPTH(4)) dut (.MCLK, .SYS_RST, .PACKET_MODE_SELECT,
    .CHIP_POSITION_PINS(CHIP), .DIN, .WRITE_ENABLE_N, .WRITE_ADDRESS_ENABLE,
    .FULL_FLAG_STROBE(1'b0), .WRITE_QUEUE_ADDR_BUS, .FULL_FLAG_N,
    .ALMOST_FULL_FLAG_N(), .READ_ENABLE_N, .READ_ADDRESS_ENABLE,
    .EMPTY_FLAG_STROBE, .READ_QUEUE_ADDR_BUS, .OUTPUT_ENABLE_N, .QOUT,
    .QOUT_OE, .OUTPUT_VALID_FLAG_N, .EMPTY_FLAG_N, .PACKET_READY_FLAG_N,
    .ALMOST_EMPTY_FLAG_N);
  read_host host (.MCLK, .host_on, .host_slow, .QOUT, .OUTPUT_VALID_FLAG_N,
    .READ_ENABLE_N);

  // 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  // ====================
  // Helpers
  function automatic logic [35:0] wd(input logic [7:0] k);
    wd = {12'h0A5, 16'h5A00, k};
  endfunction
  function automatic logic [4:0] wa(input logic [1:0] q);
    wa = {CHIP, q};
  endfunction
  function automatic logic [5:0] ra(input logic [1:0] q);
    ra = {CHIP, 1'b0, q};
  endfunction

  task tick;
    @(posedge MCLK);
    #1;
  endtask

  // Pins pass two sync flops, then flags take an edge; allow margin
  task settle;
    repeat (8) tick;
  endtask

  task chk(input logic [35:0] g, input logic [35:0] e);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task give_verdict;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  // One write port cycle; the caller ends with an idle cycle
  task wcyc(input logic we, input logic [35:0] d, input logic sel,
      input logic [4:0] a);
    WRITE_ENABLE_N = !we;
    DIN = d;
    WRITE_ADDRESS_ENABLE = sel;
    WRITE_QUEUE_ADDR_BUS = a;
    tick;
  endtask

  task wsel(input logic [4:0] a);
    wcyc(1'b0, 36'h0, 1'b1, a);
    wcyc(1'b0, 36'h0, 1'b0, a);
  endtask

  task rsel(input logic sel, input logic strobe, input logic [5:0] a);
    READ_ADDRESS_ENABLE = sel;
    EMPTY_FLAG_STROBE = strobe;
    READ_QUEUE_ADDR_BUS = a;
    tick;
    READ_ADDRESS_ENABLE = 1'b0;
    EMPTY_FLAG_STROBE = 1'b0;
    tick;
  endtask

  // Wait, bounded, until the host has logged n words
  task drain(input int n);
    for (int i = 0; i < 400 && host.got.size() < n; i++) begin
      tick;
    end
    if (host.got.size() < n) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, host.got.size(), n);
      give_verdict;
    end
  endtask

  task do_reset(input logic mode);
    SYS_RST = 1'b1;
    PACKET_MODE_SELECT = mode;
    repeat (6) tick;
    chk(FULL_FLAG_N, 1'b1);
    chk(EMPTY_FLAG_N, 1'b0);
    chk(QOUT, 36'h0);
    chk(QOUT_OE, 1'b0);
    SYS_RST = 1'b0;
    tick;
  endtask

  // ====================
  // Scenarios
  task t_basic;
    host.got.delete();
    host_on = 1'b1;
    rsel(1'b1, 1'b0, ra(1));
    wsel(wa(1));
    for (int k = 1; k <= 3; k++) begin
      wcyc(1'b1, wd(k), 1'b0, wa(1));
    end
    wcyc(1'b0, 36'h0, 1'b0, wa(1));
    drain(3);
    for (int k = 1; k <= 3; k++) begin
      chk(host.got[k-1], wd(k));
    end
    $display("test basic done");
  endtask

  // Select a new queue mid-stream: A, B and C words stay in the old queue
  task t_change;
    host.got.delete();
    host_slow = 1'b1;
    rsel(1'b1, 1'b0, ra(0));
    wsel(wa(0));
    wcyc(1'b1, wd(10), 1'b0, wa(0));
    wcyc(1'b1, wd(11), 1'b1, wa(2));
    wcyc(1'b1, wd(12), 1'b0, wa(2));
    wcyc(1'b1, wd(13), 1'b0, wa(2));
    wcyc(1'b1, wd(14), 1'b0, wa(2));
    wcyc(1'b0, 36'h0, 1'b0, wa(2));
    drain(3);
    rsel(1'b1, 1'b0, ra(2));
    drain(5);
    for (int k = 0; k < 5; k++) begin
      chk(host.got[k], wd(8'(10 + k)));
    end
    host_slow = 1'b0;
    $display("test change done");
  endtask

  task t_full;
    host_on = 1'b0;
    rsel(1'b1, 1'b0, ra(1));
    wsel(wa(3));
    for (int k = 20; k < 25; k++) begin
      wcyc(1'b1, wd(8'(k)), 1'b0, wa(3));
    end
    wcyc(1'b0, 36'h0, 1'b0, wa(3));
    settle;
    chk(FULL_FLAG_N, 1'b0);
    wsel(wa(1));
    settle;
    chk(FULL_FLAG_N, 1'b1);
    wsel(wa(3));
    settle;
    chk(FULL_FLAG_N, 1'b0);
    host.got.delete();
    rsel(1'b1, 1'b0, ra(3));
    host_on = 1'b1;
    drain(4);
    settle;
    chk(36'(host.got.size()), 36'h4);
    for (int k = 0; k < 4; k++) begin
      chk(host.got[k], wd(8'(20 + k)));
    end
    $display("test full done");
  endtask

  // Word loads with drive off, then an empty queue keeps it invalid
  task t_empty;
    host_on = 1'b0;
    OUTPUT_ENABLE_N = 1'b1;
    rsel(1'b1, 1'b0, ra(1));
    wsel(wa(1));
    wcyc(1'b1, wd(50), 1'b0, wa(1));
    wcyc(1'b0, 36'h0, 1'b0, wa(1));
    settle;
    chk(QOUT, wd(50));
    chk(OUTPUT_VALID_FLAG_N, 1'b0);
    rsel(1'b1, 1'b0, ra(0));
    settle;
    chk(QOUT, wd(50));
    chk(OUTPUT_VALID_FLAG_N, 1'b1);
    chk(EMPTY_FLAG_N, 1'b0);
    chk(QOUT_OE, 1'b0);
    OUTPUT_ENABLE_N = 1'b0;
    $display("test empty done");
  endtask

  task t_desel;
    host.got.delete();
    host_on = 1'b1;
    wsel(wa(0));
    wsel({3'h2, 2'h0});
    wcyc(1'b1, wd(60), 1'b0, {3'h2, 2'h0});
    wcyc(1'b0, 36'h0, 1'b0, {3'h2, 2'h0});
    settle;
    chk(36'(host.got.size()), 36'h0);
    chk(EMPTY_FLAG_N, 1'b0);
    rsel(1'b0, 1'b1, {3'h2, 3'h0});
    settle;
    chk(ALMOST_EMPTY_FLAG_N, 4'hF);
    rsel(1'b0, 1'b1, ra(0));
    settle;
    chk(ALMOST_EMPTY_FLAG_N, 4'h0);
    $display("test deselect done");
  endtask

  task t_packet;
    logic [35:0] pk [4];
    pk[0] = wd(40) | (36'h1 << mq_pkg::SOP_BIT);
    pk[1] = wd(41);
    pk[2] = wd(42);
    pk[3] = wd(43) | (36'h1 << mq_pkg::EOP_BIT);
    host_on = 1'b0;
    do_reset(1'b1);
    host.got.delete();
    rsel(1'b1, 1'b0, ra(0));
    wsel(wa(0));
    for (int k = 0; k < 3; k++) begin
      wcyc(1'b1, pk[k], 1'b0, wa(0));
    end
    wcyc(1'b0, 36'h0, 1'b0, wa(0));
    settle;
    chk(36'(host.got.size()), 36'h0);
    chk(PACKET_READY_FLAG_N, 1'b1);
    wcyc(1'b1, pk[3], 1'b0, wa(0));
    wcyc(1'b0, 36'h0, 1'b0, wa(0));
    settle;
    chk(PACKET_READY_FLAG_N, 1'b0);
    chk(OUTPUT_VALID_FLAG_N, 1'b0);
    host_on = 1'b1;
    drain(4);
    for (int k = 0; k < 4; k++) begin
      chk(host.got[k], pk[k]);
    end
    $display("test packet done");
  endtask

  // ====================
  // Main sequence
  initial begin
    SYS_RST = 1'b1;
    PACKET_MODE_SELECT = 1'b0;
    DIN = 36'h0;
    WRITE_ENABLE_N = 1'b1;
    WRITE_ADDRESS_ENABLE = 1'b0;
    WRITE_QUEUE_ADDR_BUS = 5'h00;
    READ_ADDRESS_ENABLE = 1'b0;
    EMPTY_FLAG_STROBE = 1'b0;
    READ_QUEUE_ADDR_BUS = 6'h00;
    OUTPUT_ENABLE_N = 1'b0;
    host_on = 1'b0;
    host_slow = 1'b0;
    do_reset(1'b0);
    t_basic;
    t_change;
    t_full;
    t_empty;
    t_desel;
    t_packet;
    give_verdict;
  end
endmodule
